// ---- core/flash_table_cfg.svh ----
`ifndef FLASH_TABLE_CFG_SVH
`define FLASH_TABLE_CFG_SVH
// Functional notes
// - Table read returns exactly one byte
// - Writes commit whole write blocks
// - Erase works on 64-byte blocks
// - No software bulk erase path
// - Stall fetches during write or erase
// - Internal timer ends write and erase
// - Invalid fetched word executes as no-op
// - Transfers pass through 8-bit table latch
// - Table read loads addressed byte into latch
// - Table write fills holding register only
// - Any byte address allowed for table ops
// - Unlock register reads as all zeros
// - Space bit clear selects EEPROM, set program
// - Config bit set overrides space select
// - Erase bit makes next start erase
// - Writes need enable bit, cleared at reset
// - Error flag set at start, cleared at end
// - Error flag one means a write or erase in progress or a refused start; reset clears it
// - Start bit software-settable, never clearable
// - Hardware clears start bit on completion
// - Complete flag sticky until firmware clears
// - 22-bit pointer, config space selected by control config bit
// - Error leaves space select bits unchanged

`define ADDR_CTRL 4'h0
`define ADDR_UNLOCK 4'h1
`define ADDR_LATCH 4'h2
`define ADDR_PTR_L 4'h3
`define ADDR_PTR_H 4'h4
`define ADDR_PTR_U 4'h5
`define ADDR_IRQ 4'h6

`define BIT_SPACE 7
`define BIT_CFG 6
`define BIT_ERASE 4
`define BIT_ERR 3
`define BIT_WRITE_ENABLE_BIT 2
`define BIT_START 1
`define BIT_IRQ 0

`define UNLOCK_1 8'h55
`define UNLOCK_2 8'hAA

`define WBLK_BYTES 64
`define WBLK_AW 6
`define EBLK_BYTES 64
`define PTR_W 22
`define FLASH_AW 16

// Must outlast streaming one whole write block out of the holding registers
`define PROG_TIME_NS 4000
`define CLK_PERIOD_NS 100
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NOP_WORD 16'h0000
`endif

// ---- core/flash_table_pkg.sv ----
package flash_table_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_WRITE
    } seq_state_t;
    typedef enum logic [1:0] {
        UNL_NONE,
        UNL_FIRST,
        UNL_ARMED
    } unlock_state_t;
endpackage

// ---- core/prog_timer.sv ----
`timescale 1ns/1ps
`include "flash_table_cfg.svh"
module prog_timer (
    input wire logic core_clk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic start, // Begin timing
    output logic busy, // Timing in progress
    output logic done // One-cycle expiry pulse
);
    logic [15:0] cnt_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 16'h0000;
        end else if (start) begin
            cnt_q <= 16'(`PROG_CYCLES);
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    assign busy = (cnt_q != 16'h0000);
    assign done = (cnt_q == 16'h0001);
endmodule

// ---- core/flash_table_access_control.sv ----
`timescale 1ns/1ps
`include "flash_table_cfg.svh"
module flash_table_access_control (
    input wire logic core_clk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic [3:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic table_read_op, // Table read request
    input wire logic table_write_op, // Table write request
    output logic table_ack, // Table op accepted
    input wire logic [15:0] fetch_addr, // Instruction fetch word address
    input wire logic fetch_req, // Instruction fetch request
    output logic fetch_stall, // Fetch held off
    output logic [15:0] fetch_word, // Fetched word, registered
    output logic fetch_valid, // Fetched word valid
    output logic fetch_is_nop, // Fetched word replaced by no-op
    output logic [`FLASH_AW-1:0] flash_addr, // Flash word address
    output logic flash_rd, // Flash read strobe
    input wire logic [15:0] flash_rdata, // Flash read word, same cycle
    output logic flash_wr, // Flash word program strobe
    output logic [15:0] flash_wdata, // Flash program word
    output logic flash_erase, // Flash 64-byte block erase strobe
    output logic [1:0] target_space, // 0 EEPROM, 1 program, 2 config
    output logic write_complete_irq_flag // Write done flag, sticky
);
    logic [7:0] table_byte_latch_q;
    logic [`PTR_W-1:0] table_byte_pointer_q;
    logic memory_space_select_q;
    logic config_space_select_q;
    logic erase_sel_q;
    logic write_enable_bit_q;
    logic write_error_flag_q;
    logic start_q;
    logic irq_q;
    logic [7:0] hold_mem [`WBLK_BYTES];
    logic [7:0] rdata_q;
    logic [15:0] fetch_word_q;
    logic fetch_valid_q;
    logic fetch_nop_q;
    flash_table_pkg::seq_state_t state_q;
    flash_table_pkg::unlock_state_t unl_q;
    logic [`WBLK_AW-1:0] wcnt_q;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic busy;
    logic go;
    logic wr_ctrl;
    logic [`FLASH_AW-1:0] blk_base;
    logic word_valid;
    logic [`WBLK_AW:0] wr_seen_q;

    assign busy = (state_q != flash_table_pkg::ST_IDLE);
    assign wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
    // Start accepted only when enabled, unlocked and idle
    assign go = wr_ctrl && reg_wdata[`BIT_START] && !start_q && write_enable_bit_q
        && (unl_q == flash_table_pkg::UNL_ARMED) && !busy;
    assign blk_base = {table_byte_pointer_q[`FLASH_AW:`WBLK_AW], {(`WBLK_AW-1){1'b0}}};

    prog_timer u_timer (
        .core_clk(core_clk),
        .nrst(nrst),
        .start(tmr_start),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Unlock sequence tracker
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            unl_q <= flash_table_pkg::UNL_NONE;
        end else if (reg_wr && reg_addr == `ADDR_UNLOCK) begin
            if (reg_wdata == `UNLOCK_1) begin
                unl_q <= flash_table_pkg::UNL_FIRST;
            end else if (reg_wdata == `UNLOCK_2 && unl_q == flash_table_pkg::UNL_FIRST) begin
                unl_q <= flash_table_pkg::UNL_ARMED;
            end else begin
                unl_q <= flash_table_pkg::UNL_NONE;
            end
        end else if (reg_wr) begin
            unl_q <= flash_table_pkg::UNL_NONE;
        end
    end

    // Control bits
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            memory_space_select_q <= 1'b0;
            config_space_select_q <= 1'b0;
            erase_sel_q <= 1'b0;
            write_enable_bit_q <= 1'b0;
        end else if (wr_ctrl) begin
            // Space bits only change by software, never on error
            memory_space_select_q <= reg_wdata[`BIT_SPACE];
            config_space_select_q <= reg_wdata[`BIT_CFG];
            erase_sel_q <= reg_wdata[`BIT_ERASE];
            write_enable_bit_q <= reg_wdata[`BIT_WRITE_ENABLE_BIT];
        end
    end

    // Start bit: software sets, hardware clears
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            start_q <= 1'b0;
        end else if (go) begin
            start_q <= 1'b1;
        end else if (state_q != flash_table_pkg::ST_IDLE && tmr_done) begin
            start_q <= 1'b0;
        end
    end

    // Error flag: set on start, cleared on clean completion
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            write_error_flag_q <= 1'b0;
        end else if (go) begin
            write_error_flag_q <= 1'b1;
        end else if (busy && tmr_done) begin
            write_error_flag_q <= 1'b0;
        end else if (wr_ctrl && reg_wdata[`BIT_START] && !go && !start_q) begin
            write_error_flag_q <= 1'b1;
        end else if (wr_ctrl && !reg_wdata[`BIT_ERR]) begin
            write_error_flag_q <= 1'b0;
        end
    end

    // Completion flag, set wins over clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else if (busy && tmr_done) begin
            irq_q <= 1'b1;
        end else if (reg_wr && reg_addr == `ADDR_IRQ && !reg_wdata[`BIT_IRQ]) begin
            irq_q <= 1'b0;
        end
    end

    // Program/erase sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= flash_table_pkg::ST_IDLE;
            wcnt_q <= '0;
        end else begin
            unique case (state_q)
                flash_table_pkg::ST_IDLE: begin
                    wcnt_q <= '0;
                    if (go) begin
                        // Erase choice comes with the starting write itself
                        state_q <= reg_wdata[`BIT_ERASE] ? flash_table_pkg::ST_ERASE
                                                         : flash_table_pkg::ST_WRITE;
                    end
                end
                flash_table_pkg::ST_ERASE: begin
                    if (tmr_done) begin
                        state_q <= flash_table_pkg::ST_IDLE;
                    end
                end
                flash_table_pkg::ST_WRITE: begin
                    if (wcnt_q != `WBLK_AW'(`WBLK_BYTES/2)) begin
                        wcnt_q <= wcnt_q + `WBLK_AW'(1);
                    end
                    if (tmr_done) begin
                        state_q <= flash_table_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign tmr_start = go;
    // Erase only on a 64-byte block, no bulk-erase path exists
    assign flash_erase = (state_q == flash_table_pkg::ST_ERASE) && tmr_done;
    // Whole holding block streamed out only for a non-erase start
    assign flash_wr = (state_q == flash_table_pkg::ST_WRITE)
        && (wcnt_q < `WBLK_AW'(`WBLK_BYTES/2));
    assign flash_wdata = {hold_mem[{wcnt_q[`WBLK_AW-2:0], 1'b1}],
                          hold_mem[{wcnt_q[`WBLK_AW-2:0], 1'b0}]};
    assign flash_rd = !busy && (table_read_op || fetch_req);
    always_comb begin
        if (state_q == flash_table_pkg::ST_WRITE) begin
            flash_addr = blk_base | `FLASH_AW'(wcnt_q);
        end else if (state_q == flash_table_pkg::ST_ERASE) begin
            flash_addr = {table_byte_pointer_q[`FLASH_AW:6], 5'h00};
        end else if (table_read_op) begin
            flash_addr = table_byte_pointer_q[`FLASH_AW:1];
        end else begin
            flash_addr = fetch_addr;
        end
    end
    assign fetch_stall = busy || (fetch_req && table_read_op);
    assign table_ack = !busy && (table_read_op || table_write_op);
    assign target_space = config_space_select_q ? 2'h2 : {1'b0, memory_space_select_q};

    // Table latch and holding registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            table_byte_latch_q <= 8'h00;
        end else if (table_ack && table_read_op) begin
            // One byte picked from the word by pointer bit 0
            table_byte_latch_q <= table_byte_pointer_q[0] ? flash_rdata[15:8]
                                                         : flash_rdata[7:0];
        end else if (reg_wr && reg_addr == `ADDR_LATCH) begin
            table_byte_latch_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (table_ack && table_write_op && !table_read_op) begin
            hold_mem[table_byte_pointer_q[`WBLK_AW-1:0]] <= table_byte_latch_q;
        end
    end

    // Table pointer registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            table_byte_pointer_q <= '0;
        end else if (reg_wr && reg_addr == `ADDR_PTR_L) begin
            table_byte_pointer_q[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == `ADDR_PTR_H) begin
            table_byte_pointer_q[15:8] <= reg_wdata;
        end else if (reg_wr && reg_addr == `ADDR_PTR_U) begin
            table_byte_pointer_q[21:16] <= reg_wdata[5:0];
        end
    end

    // Fetch path: illegal word returns as no-op
    assign word_valid = (flash_rdata != 16'hFFFF);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fetch_word_q <= 16'h0000;
            fetch_valid_q <= 1'b0;
            fetch_nop_q <= 1'b0;
        end else begin
            fetch_valid_q <= fetch_req && !fetch_stall;
            if (fetch_req && !fetch_stall) begin
                fetch_word_q <= word_valid ? flash_rdata : `NOP_WORD;
                fetch_nop_q <= !word_valid;
            end
        end
    end

    // Register read port
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_CTRL: rdata_q <= {memory_space_select_q, config_space_select_q, 1'b0,
                    erase_sel_q, write_error_flag_q, write_enable_bit_q, start_q, 1'b0};
                `ADDR_UNLOCK: rdata_q <= 8'h00;
                `ADDR_LATCH: rdata_q <= table_byte_latch_q;
                `ADDR_PTR_L: rdata_q <= table_byte_pointer_q[7:0];
                `ADDR_PTR_H: rdata_q <= table_byte_pointer_q[15:8];
                `ADDR_PTR_U: rdata_q <= {2'b00, table_byte_pointer_q[21:16]};
                `ADDR_IRQ: rdata_q <= {7'h00, irq_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign fetch_word = fetch_word_q;
    assign fetch_valid = fetch_valid_q;
    assign fetch_is_nop = fetch_nop_q;
    assign write_complete_irq_flag = irq_q;

    // Words programmed since the last start, for the block check
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_seen_q <= '0;
        end else if (go) begin
            wr_seen_q <= '0;
        end else if (flash_wr) begin
            wr_seen_q <= wr_seen_q + 7'h01;
        end
    end

    a_start_clears: assert property (@(posedge core_clk) disable iff (!nrst)
        busy && tmr_done |=> !start_q && !write_error_flag_q)
        else $error("start bit not cleared at completion");
    a_stall_busy: assert property (@(posedge core_clk) disable iff (!nrst)
        busy |-> fetch_stall && !table_ack && !flash_rd)
        else $error("access while programming");
    a_err_on_go: assert property (@(posedge core_clk) disable iff (!nrst)
        go |=> write_error_flag_q && start_q && busy)
        else $error("start did not raise error and busy");
    a_write_enable_bit_needed: assert property (@(posedge core_clk) disable iff (!nrst)
        !write_enable_bit_q |-> !go)
        else $error("start without write enable");
    a_irq_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
        irq_q && !(reg_wr && reg_addr == `ADDR_IRQ) |=> irq_q)
        else $error("completion flag dropped");
    a_irq_set: assert property (@(posedge core_clk) disable iff (!nrst)
        busy && tmr_done |=> irq_q && !busy)
        else $error("completion flag not set");
    a_unlock_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_rd && reg_addr == `ADDR_UNLOCK |=> reg_rdata == 8'h00)
        else $error("unlock register read nonzero");
    a_erase_path: assert property (@(posedge core_clk) disable iff (!nrst)
        go |=> ((state_q == flash_table_pkg::ST_ERASE) == erase_sel_q))
        else $error("erase choice differs from erase select");
    a_target_cfg: assert property (@(posedge core_clk) disable iff (!nrst)
        config_space_select_q |-> target_space == 2'h2)
        else $error("config select ignored");

    a_block_whole: assert property (@(posedge core_clk) disable iff (!nrst)
        state_q == flash_table_pkg::ST_WRITE && tmr_done |-> wr_seen_q == 7'h20)
        else $error("write ended before whole block programmed");
    a_erase_once: assert property (@(posedge core_clk) disable iff (!nrst)
        flash_erase |=> !flash_erase)
        else $error("erase strobe longer than one cycle");
    a_timer_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        busy && !tmr_done |=> busy)
        else $error("operation ended before timer expiry");
    a_start_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
        start_q && !(busy && tmr_done) |=> start_q)
        else $error("start bit cleared early");
    a_err_keeps_space: assert property (@(posedge core_clk) disable iff (!nrst)
        write_error_flag_q && !wr_ctrl |=> $stable(memory_space_select_q)
        && $stable(config_space_select_q))
        else $error("space select changed without software");
    a_nop_fetch: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid_q && fetch_nop_q |-> fetch_word_q == `NOP_WORD)
        else $error("invalid word not replaced by no-op");
    a_fetch_plain: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid_q && !fetch_nop_q |-> fetch_word_q != 16'hFFFF)
        else $error("invalid word passed to core");
    a_hold_only: assert property (@(posedge core_clk) disable iff (!nrst)
        table_ack && table_write_op |-> !flash_wr && !flash_erase)
        else $error("table write touched flash array");

    c_write: cover property (@(posedge core_clk) disable iff (!nrst)
        go && !reg_wdata[`BIT_ERASE] ##[1:60] !busy);
    c_fetch_nop: cover property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid_q && fetch_nop_q);
    c_bad_start: cover property (@(posedge core_clk) disable iff (!nrst)
        wr_ctrl && reg_wdata[`BIT_START] && !go && !start_q);
    c_erase: cover property (@(posedge core_clk) disable iff (!nrst) flash_erase);
    c_tread: cover property (@(posedge core_clk) disable iff (!nrst)
        table_ack && table_read_op);
endmodule

// ---- testbench/flash_array_model.sv ----
`timescale 1ns/1ps
module flash_array_model (
    input wire logic core_clk, // Clock
    input wire logic [15:0] flash_addr, // Word address
    input wire logic flash_rd, // Read strobe
    output logic [15:0] flash_rdata, // Read word, same cycle
    input wire logic flash_wr, // Program strobe
    input wire logic [15:0] flash_wdata, // Program word
    input wire logic flash_erase // Block erase strobe
);
    logic [15:0] mem [0:65535];
    logic [15:0] last_q;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = {i[7:0] ^ 8'h3C, i[15:8] ^ 8'hA5};
        end
        last_q = 16'h0000;
    end
    // Unselected read lines do not echo the last word
    assign flash_rdata = flash_rd ? mem[flash_addr] : ~last_q;
    always @(posedge core_clk) begin
        if (flash_rd) begin
            last_q <= mem[flash_addr];
        end
        if (flash_wr) begin
            mem[flash_addr] <= flash_wdata;
        end
        if (flash_erase) begin
            for (int i = 0; i < 32; i++) begin
                mem[{flash_addr[15:5], i[4:0]}] <= 16'hFFFF;
            end
        end
    end
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "flash_table_cfg.svh"
module testbench;
    logic core_clk, nrst, reg_wr, reg_rd, table_read_op, table_write_op, fetch_req;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic table_ack, fetch_stall, fetch_valid, fetch_is_nop, flash_rd, flash_wr, flash_erase;
    logic write_complete_irq_flag;
    logic [15:0] fetch_addr, fetch_word, flash_rdata, flash_wdata;
    logic [`FLASH_AW-1:0] flash_addr;
    logic [1:0] target_space;
    logic [31:0] seed = 32'hA7F7;
    logic [15:0] exp_mem [int];
    logic [7:0] hold [0:63];
    logic [21:0] p;
    logic [15:0] w;
    int num_errors = 0, num_checks = 0, cyc = 0;
    int busy_cnt = 0, wr_cnt = 0, er_cnt = 0, fv_bad = 0;
    flash_table_access_control flash_table_access_control_i (.core_clk, .nrst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .table_read_op, .table_write_op, .table_ack,
        .fetch_addr, .fetch_req, .fetch_stall, .fetch_word, .fetch_valid, .fetch_is_nop,
        .flash_addr, .flash_rd, .flash_rdata, .flash_wr, .flash_wdata, .flash_erase,
        .target_space, .write_complete_irq_flag);
    flash_array_model flash_array_model_i (.core_clk, .flash_addr, .flash_rd, .flash_rdata,
        .flash_wr, .flash_wdata, .flash_erase);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] mget(int a);
        return exp_mem.exists(a) ? exp_mem[a] : {a[7:0] ^ 8'h3C, a[15:8] ^ 8'hA5};
    endfunction
    task automatic summarize();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        num_checks++;
        if (seen !== expv) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
    endtask
    task automatic tbl(input bit wop);
        @(posedge core_clk);
        if (wop) table_write_op <= 1'b1;
        else table_read_op <= 1'b1;
        @(negedge core_clk);
        check(table_ack, 1);
        @(posedge core_clk);
        table_write_op <= 1'b0;
        table_read_op <= 1'b0;
    endtask
    task automatic setptr(input logic [21:0] q);
        wr(`ADDR_PTR_L, q[7:0]);
        wr(`ADDR_PTR_H, q[15:8]);
        wr(`ADDR_PTR_U, {2'b00, q[21:16]});
    endtask
    task automatic fch(input logic [15:0] a, input logic [15:0] ew, input logic en);
        @(posedge core_clk);
        fetch_addr <= a;
        fetch_req <= 1'b1;
        @(posedge core_clk);
        fetch_req <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            if (fetch_valid === 1'b1) break;
        end
        check(fetch_valid, 1);
        check(fetch_word, ew);
        check(fetch_is_nop, en);
    endtask
    task automatic prog(input logic [21:0] q, input bit er);
        int blk;
        blk = int'(q[16:1]) & 32'hFFE0;
        setptr(q);
        wr(`ADDR_UNLOCK, `UNLOCK_1);
        wr(`ADDR_UNLOCK, `UNLOCK_2);
        busy_cnt = 0;
        wr_cnt = 0;
        er_cnt = 0;
        fv_bad = 0;
        table_read_op <= 1'b1;
        fetch_req <= 1'b1;
        wr(`ADDR_CTRL, er ? 8'h96 : 8'h86);
        rd(`ADDR_CTRL, rv);
        check({rv[3], rv[1]}, 2'b11);
        if (er) begin
            wr(`ADDR_CTRL, 8'h94);
            rd(`ADDR_CTRL, rv);
            check(rv[1], 1);
        end
        for (int i = 0; i < 60 && write_complete_irq_flag !== 1'b1; i++) @(negedge core_clk);
        @(posedge core_clk);
        table_read_op <= 1'b0;
        fetch_req <= 1'b0;
        check(busy_cnt[15:0], `PROG_CYCLES);
        check(fv_bad[15:0], 0);
        check(wr_cnt[15:0], er ? 0 : 32);
        check(er_cnt[15:0], er ? 1 : 0);
        rd(`ADDR_CTRL, rv);
        check({rv[3], rv[1]}, 2'b00);
        rd(`ADDR_IRQ, rv);
        check(rv[0], 1);
        wr(`ADDR_IRQ, 8'h00);
        @(negedge core_clk);
        check(write_complete_irq_flag, 0);
        for (int i = 0; i < 32; i++) begin
            exp_mem[blk + i] = er ? 16'hFFFF : {hold[2 * i + 1], hold[2 * i]};
            check(flash_array_model_i.mem[blk + i], mget(blk + i));
        end
    endtask
    always @(negedge core_clk) begin
        if (table_read_op && !table_ack) busy_cnt++;
        if (table_read_op && !table_ack && (fetch_valid || flash_rd)) fv_bad++;
        if (flash_wr) wr_cnt++;
        if (flash_erase) er_cnt++;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        {nrst, reg_wr, reg_rd, table_read_op, table_write_op, fetch_req} = '0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        fetch_addr = 16'h0000;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`ADDR_CTRL, rv);
        check(rv, 8'h00);
        wr(`ADDR_UNLOCK, `UNLOCK_1);
        rd(`ADDR_UNLOCK, rv);
        check(rv, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`ADDR_CTRL, {i[1], i[0], 6'h00});
            @(negedge core_clk);
            check(target_space, i[0] ? 2'd2 : {1'b0, i[1]});
        end
        wr_cnt = 0;
        wr(`ADDR_UNLOCK, `UNLOCK_1);
        wr(`ADDR_UNLOCK, `UNLOCK_2);
        wr(`ADDR_CTRL, 8'h82);
        rd(`ADDR_CTRL, rv);
        check(rv, 8'h88);
        wr(`ADDR_CTRL, 8'hC6);
        rd(`ADDR_CTRL, rv);
        check(rv, 8'hCC);
        check(wr_cnt[15:0], 0);
        wr(`ADDR_CTRL, 8'h00);
        for (int k = 0; k < 8; k++) begin
            p = 22'(xs() & 32'h1FFFF);
            setptr(p);
            tbl(0);
            rd(`ADDR_LATCH, rv);
            w = mget(int'(p[16:1]));
            check(rv, p[0] ? w[15:8] : w[7:0]);
        end
        wr(`ADDR_CTRL, 8'h84);
        setptr(22'h000A40);
        wr_cnt = 0;
        for (int b = 0; b < 64; b++) begin
            hold[b] = 8'(xs());
            wr(`ADDR_PTR_L, 8'h40 + 8'(b));
            wr(`ADDR_LATCH, hold[b]);
            tbl(1);
        end
        check(wr_cnt[15:0], 0);
        prog(22'h000A51, 0);
        prog(22'h001283, 1);
        fch(16'h0941, 16'h0000, 1);
        fch(16'h0525, mget(32'h525), 0);
        summarize();
    end
endmodule
